/* File: hdl/scu_consts.svh */
// Constants of the smart card UART register bank: offsets, fields, resets, sizes.
// Assumes inclusion by bare name from every file that needs a number.
`ifndef SCU_CONSTS_SVH
`define SCU_CONSTS_SVH

// Register offsets on the special function register port
`define SCU_ADDR_BUF 8'haa
`define SCU_ADDR_SEL 8'hab
`define SCU_ADDR_ETU_LO 8'hac
`define SCU_ADDR_ETU_HI 8'had
`define SCU_ADDR_IRQ 8'hae

// Reset values
`define SCU_RST_SEL 8'h08
`define SCU_RST_IER 8'h00
`define SCU_RST_ETU_LO 8'h74
`define SCU_RST_ETU_HI 8'h01
`define SCU_RST_BUF 8'h00

// Enable and identification bit positions
`define SCU_B_TXE 7
`define SCU_B_OVC 5
`define SCU_B_VLT 4
`define SCU_B_WTO 3
`define SCU_B_TXD 2
`define SCU_B_RXD 1
`define SCU_B_PAR 0
`define SCU_IRQ_MASK 8'hbf

// Selection register fields, then the unit high register compensation bit and mask
`define SCU_B_BGEN 6
`define SCU_B_REP 4
`define SCU_B_PS_HI 3
`define SCU_B_PS_LO 2
`define SCU_B_ALT 1
`define SCU_B_BANK 0
`define SCU_SEL_MASK 8'h5f
`define SCU_B_COMP 7
`define SCU_ETU_HI_MASK 8'h87

// Repetition limits, frame layout and FIFO depth
`define SCU_REP_FIVE 3'h5
`define SCU_REP_FOUR 3'h4
`define SCU_LAST_BIT 4'h9
`define SCU_FIFO_DEPTH 16

`endif

/* File: hdl/scu_pkg.sv */
// Types shared by the smart card UART register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package scu_pkg;
  typedef enum logic [5:0] {
    SCU_IDLE = 6'h01,
    SCU_TXB = 6'h02,
    SCU_TXC = 6'h04,
    SCU_RXB = 6'h08,
    SCU_RXN = 6'h10,
    SCU_GAP = 6'h20
  } scu_state_t;
endpackage

/* File: hdl/scu_stream_if.sv */
// Valid/ready byte stream between the character engine and its buffers.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface scu_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: hdl/scu_fifo.sv */
// Receive FIFO: small memory with a registered output word.
// Assumes one clock, asynchronous active-low reset.
`timescale 1ns/100ps
module scu_fifo import scu_pkg::*; #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic core_clk, // System clock
  input wire logic nrst, // Asynchronous reset, low
  scu_stream_if.snk in_s, // Filling side
  scu_stream_if.src out_s // Draining side
);
  localparam int AW = $clog2(D);

  if (D < 2 || (1 << AW) != D) begin : g_chk
    $error("scu_fifo depth must be a power of two, at least 2");
  end

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [AW:0] cnt_q;
  logic ov_q;
  logic [W-1:0] od_q;
  logic push;
  logic pop;

  // Full counts memory words only, so ready drops honestly
  assign in_s.ready = cnt_q != (AW+1)'(D);
  assign push = in_s.valid && in_s.ready;
  assign pop = (cnt_q != '0) && (!ov_q || out_s.ready);
  assign out_s.valid = ov_q;
  assign out_s.data = od_q;

  ////////////////////////////////////////////////////////////////////////////
  // Storage, no reset needed on the array
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wptr_q] <= in_s.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wptr_q <= wptr_q + AW'(1);
      if (pop) rptr_q <= rptr_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Registered output word
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (pop) begin
      ov_q <= 1'b1;
      od_q <= mem_q[rptr_q];
    end else if (out_s.ready) begin
      ov_q <= 1'b0;
    end
  end
endmodule

/* File: hdl/scu_regs.sv */
// Smart card UART control registers with a half-duplex character engine.
// Assumes a byte-wide special function register port on core_clk and an
// open-drain card I/O line resolved outside.
`timescale 1ns/100ps
`include "scu_consts.svh"

module scu_regs import scu_pkg::*; #(
  parameter int FIFO_DEPTH = `SCU_FIFO_DEPTH
) (
  input wire logic core_clk, // System clock, 10 MHz
  input wire logic nrst, // Asynchronous reset, low
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic sfr_wr, // Write strobe
  input wire logic sfr_rd, // Read strobe
  output logic [7:0] sfr_rdata, // Read data, next cycle
  input wire logic conv_inverse, // 1 selects inverse convention
  input wire logic [8:0] guard_time_value, // Guard time in time units
  input wire logic overcurrent_evt, // Card current fault pulse
  input wire logic voltage_fault_evt, // Card voltage fault pulse
  input wire logic wait_timeout_evt, // Waiting counter expiry pulse
  input wire logic port_clk, // Normal port level for card clock pin
  input wire logic card_io_in, // Card I/O line level
  output logic card_io_out, // Card I/O drive value, always low
  output logic card_io_oe, // Card I/O pulls low while high
  output logic card_clk, // Card clock pin
  output logic irq // Interrupt request
);
  if (FIFO_DEPTH < 2) begin : g_chk
    $error("scu_regs needs a FIFO depth of at least 2");
  end

  logic [7:0] ier_q, sel_q, etu_lo_q, etu_hi_q, txbuf_q, rxbuf_q, id_q, rdata_q;
  logic [2:0] io_sync_q;
  logic io_s_q;
  logic tx_empty_q, rx_flag_q, irq_q, bg_en_q, alt_q, card_clk_q, io_drv_q, retry_q;
  logic [2:0] pre_cnt_q, rep_q;
  logic [10:0] etu_cnt_q, bg_etu_q;
  logic [8:0] bg_cnt_q;
  logic [3:0] bitn_q;
  logic [9:0] shf_q;
  scu_state_t st_q;
  logic bank, sel_buf, wr_tx, rd_rx, rd_id, tick, ebnd, guard_ok;
  logic load_tx, txd_p, rxd_p, par_p, push_d;
  logic [2:0] rep_lim, pre_top;
  logic [10:0] etu, bit_len;
  logic [8:0] rx_log;
  logic [7:0] push_data;

  scu_stream_if #(.W(8)) fill_s ();
  scu_stream_if #(.W(8)) drain_s ();

  scu_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .nrst(nrst),
    .in_s(fill_s),
    .out_s(drain_s)
  );

  // Same function maps logical to line order and back
  function automatic logic [8:0] conv_map(input logic [8:0] x, input logic inv);
    logic [8:0] r;
    r = x;
    for (int i = 0; i < 8; i++) begin
      r[i] = x[7-i];
    end
    return inv ? ~r : x;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Decode; the bank bit picks which set answers at shared offsets
  assign bank = sel_q[`SCU_B_BANK];
  assign sel_buf = sfr_addr == `SCU_ADDR_BUF;
  assign wr_tx = sfr_wr && sel_buf && !bank;
  assign rd_rx = sfr_rd && sel_buf && bank;
  assign rd_id = sfr_rd && (sfr_addr == `SCU_ADDR_IRQ) && !bank;
  assign rep_lim = sel_q[`SCU_B_REP] ? `SCU_REP_FOUR : `SCU_REP_FIVE;
  assign etu = {etu_hi_q[2:0], etu_lo_q};
  // Length loaded is for the next bit; even bits lose one tick when compensating
  assign bit_len = etu - 11'(etu_hi_q[`SCU_B_COMP] && bitn_q[0]);
  assign guard_ok = !bg_en_q || (bg_cnt_q == '0);

  // Pin input: three flops, a change counts when second and third agree
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      io_sync_q <= 3'h7;
      io_s_q <= 1'b1;
    end else begin
      io_sync_q <= {io_sync_q[1:0], card_io_in};
      if (io_sync_q[1] == io_sync_q[2]) io_s_q <= io_sync_q[2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; reserved bits are masked off on write
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ier_q <= `SCU_RST_IER;
      sel_q <= `SCU_RST_SEL;
      etu_lo_q <= `SCU_RST_ETU_LO;
      etu_hi_q <= `SCU_RST_ETU_HI;
      txbuf_q <= `SCU_RST_BUF;
    end else if (sfr_wr) begin
      if (sfr_addr == `SCU_ADDR_SEL) sel_q <= sfr_wdata & `SCU_SEL_MASK;
      if (sfr_addr == `SCU_ADDR_IRQ && bank) ier_q <= sfr_wdata & `SCU_IRQ_MASK;
      if (sfr_addr == `SCU_ADDR_ETU_LO && bank) etu_lo_q <= sfr_wdata;
      if (sfr_addr == `SCU_ADDR_ETU_HI && bank) etu_hi_q <= sfr_wdata & `SCU_ETU_HI_MASK;
      if (wr_tx) txbuf_q <= sfr_wdata;
    end
  end

  // Registered read data; unmapped offsets read zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `SCU_ADDR_BUF: rdata_q <= bank ? rxbuf_q : 8'h00;
        `SCU_ADDR_SEL: rdata_q <= sel_q;
        `SCU_ADDR_ETU_LO: rdata_q <= bank ? etu_lo_q : 8'h00;
        `SCU_ADDR_ETU_HI: rdata_q <= bank ? etu_hi_q : {tx_empty_q, 5'h00, rx_flag_q, 1'b0};
        `SCU_ADDR_IRQ: rdata_q <= bank ? ier_q : id_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign sfr_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Alternate card clock: toggle every 1,2,4,8 system cycles
  assign pre_top = 3'((4'h1 << sel_q[`SCU_B_PS_HI:`SCU_B_PS_LO]) - 4'h1);
  assign tick = (pre_cnt_q == pre_top) && !alt_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt_q <= 3'h0;
      alt_q <= 1'b0;
      card_clk_q <= 1'b0;
    end else begin
      pre_cnt_q <= (pre_cnt_q >= pre_top) ? 3'h0 : pre_cnt_q + 3'h1;
      if (pre_cnt_q >= pre_top) alt_q <= !alt_q;
      card_clk_q <= sel_q[`SCU_B_ALT] ? alt_q : port_clk;
    end
  end
  assign card_clk = card_clk_q;

  // Block guard counter counts whole time units down to zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      bg_en_q <= 1'b0;
      bg_cnt_q <= 9'h000;
      bg_etu_q <= 11'h000;
    end else begin
      bg_en_q <= sel_q[`SCU_B_BGEN];
      if (tick) bg_etu_q <= (bg_etu_q >= etu - 11'h1) ? 11'h000 : bg_etu_q + 11'h1;
      if (sel_q[`SCU_B_BGEN] && !bg_en_q) begin
        bg_cnt_q <= guard_time_value;
      end else if (st_q == SCU_IDLE && !io_s_q) begin
        bg_cnt_q <= guard_time_value;
      end else if (tick && bg_etu_q >= etu - 11'h1 && bg_cnt_q != 9'h000) begin
        bg_cnt_q <= bg_cnt_q - 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Character engine, half duplex, one bit per time unit
  // Boundary on the tick that takes the count to zero, so a unit is exactly etu ticks
  assign ebnd = tick && (etu_cnt_q == 11'h001);
  assign rx_log = conv_map(shf_q[9:1], conv_inverse);
  assign fill_s.valid = push_d;
  assign fill_s.data = push_data;
  assign push_data = rx_log[7:0];
  assign card_io_out = 1'b0;
  assign card_io_oe = io_drv_q;

  // Receive evaluation is combinational on the final sample
  always_comb begin
    push_d = 1'b0;
    if (st_q == SCU_RXB && bitn_q == 4'ha) begin
      push_d = !(^rx_log) || (rep_q + 3'h1 >= rep_lim);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= SCU_IDLE;
      etu_cnt_q <= 11'h000;
      bitn_q <= 4'h0;
      shf_q <= 10'h3ff;
      rep_q <= 3'h0;
      io_drv_q <= 1'b0;
      retry_q <= 1'b0;
      load_tx <= 1'b0;
      txd_p <= 1'b0;
      rxd_p <= 1'b0;
      par_p <= 1'b0;
    end else begin
      load_tx <= 1'b0;
      txd_p <= 1'b0;
      rxd_p <= 1'b0;
      par_p <= 1'b0;
      if (tick && etu_cnt_q != 11'h000) etu_cnt_q <= etu_cnt_q - 11'h001;
      unique case (st_q)
        SCU_IDLE: begin
          io_drv_q <= 1'b0;
          if (!tx_empty_q && guard_ok && io_s_q) begin
            st_q <= SCU_TXB;
            shf_q <= {conv_map({^txbuf_q, txbuf_q}, conv_inverse), 1'b0};
            load_tx <= 1'b1;
            rep_q <= 3'h0;
            bitn_q <= 4'h0;
            io_drv_q <= 1'b1;
            etu_cnt_q <= etu - 11'(etu_hi_q[`SCU_B_COMP]); // Start bit is even
          end else if (!io_s_q) begin
            st_q <= SCU_RXB;
            bitn_q <= 4'h0;
            etu_cnt_q <= etu >> 1;
          end
        end
        SCU_TXB: if (ebnd) begin
          bitn_q <= bitn_q + 4'h1;
          etu_cnt_q <= bit_len;
          if (bitn_q == `SCU_LAST_BIT) begin
            io_drv_q <= 1'b0;
            st_q <= SCU_TXC;
            etu_cnt_q <= etu >> 1;
          end else begin
            io_drv_q <= !shf_q[bitn_q + 4'h1];
          end
        end
        SCU_TXC: if (ebnd) begin
          st_q <= SCU_GAP;
          etu_cnt_q <= etu;
          retry_q <= 1'b0;
          if (io_s_q || rep_q + 3'h1 >= rep_lim) begin
            txd_p <= 1'b1;
            par_p <= !io_s_q;
          end else begin
            rep_q <= rep_q + 3'h1;
            retry_q <= 1'b1;
          end
        end
        SCU_RXB: begin
          if (bitn_q == 4'ha) begin
            st_q <= SCU_RXN;
            etu_cnt_q <= etu;
            if (push_d && fill_s.ready) begin
              rxd_p <= 1'b1;
              par_p <= ^rx_log;
              rep_q <= 3'h0;
              bitn_q <= 4'h0;
            end else begin
              if (^rx_log) rep_q <= rep_q + 3'h1;
              bitn_q <= 4'h1; // Full FIFO also asks the card to repeat
            end
          end else if (ebnd) begin
            if (bitn_q == 4'h0 && io_s_q) begin
              st_q <= SCU_IDLE;
            end else begin
              shf_q[bitn_q] <= io_s_q;
              bitn_q <= bitn_q + 4'h1;
              etu_cnt_q <= bit_len;
            end
          end
        end
        SCU_RXN: if (ebnd) begin
          etu_cnt_q <= etu;
          if (bitn_q == 4'h0 || io_drv_q) begin
            io_drv_q <= 1'b0;
            st_q <= SCU_GAP;
          end else begin
            io_drv_q <= 1'b1;
          end
        end
        SCU_GAP: if (ebnd) begin
          if (retry_q) begin
            st_q <= SCU_TXB;
            retry_q <= 1'b0;
            bitn_q <= 4'h0;
            io_drv_q <= 1'b1;
            etu_cnt_q <= etu - 11'(etu_hi_q[`SCU_B_COMP]); // Start bit is even
          end else begin
            st_q <= SCU_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer flags; a software write wins over a same-cycle load_tx, which comes one cycle after the copy itself
  assign drain_s.ready = !rx_flag_q;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_empty_q <= 1'b1;
      rx_flag_q <= 1'b0;
      rxbuf_q <= `SCU_RST_BUF;
    end else begin
      if (wr_tx) tx_empty_q <= 1'b0;
      else if (load_tx) tx_empty_q <= 1'b1;
      if (drain_s.valid && !rx_flag_q) begin
        rxbuf_q <= drain_s.data;
        rx_flag_q <= 1'b1;
      end else if (rd_rx) begin
        rx_flag_q <= 1'b0;
      end
    end
  end

  // Sticky identification flags, cleared by reading them; set wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      id_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      id_q <= (rd_id ? 8'h00 : id_q) | ({load_tx, 1'b0, overcurrent_evt, voltage_fault_evt,
               wait_timeout_evt, txd_p, rxd_p, par_p} & `SCU_IRQ_MASK);
      irq_q <= |(id_q & ier_q);
    end
  end
  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  a_irq_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 irq == |($past(id_q) & $past(ier_q))) else $error("irq not gated by enables");
  a_ier_store: assert property (@(posedge core_clk) disable iff (!nrst)
    sfr_wr && sfr_addr == `SCU_ADDR_IRQ && bank |=> ier_q == ($past(sfr_wdata) & 8'hbf))
    else $error("enable register not stored");
  a_guard_load: assert property (@(posedge core_clk) disable iff (!nrst)
    sel_q[`SCU_B_BGEN] && !bg_en_q |=> bg_cnt_q == $past(guard_time_value))
    else $error("guard counter not loaded");
  a_guard_hold: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q == SCU_IDLE && bg_en_q && bg_cnt_q != 9'h000 |=> !load_tx)
    else $error("transmit started inside block guard");
  a_txe_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    wr_tx |=> !tx_empty_q) else $error("empty flag not cleared by write");
  a_rx_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    rd_rx && rx_flag_q |=> !rx_flag_q) else $error("received flag not cleared by read");
  a_rx_read: assert property (@(posedge core_clk) disable iff (!nrst)
    rd_rx |=> sfr_rdata == $past(rxbuf_q)) else $error("receive buffer read wrong");
  a_rep_limit: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q == SCU_TXC && ebnd && !io_s_q && rep_q + 3'h1 < rep_lim |=> !par_p && retry_q)
    else $error("parity reported before repetitions used");
  a_clk_route: assert property (@(posedge core_clk) disable iff (!nrst)
    sel_q[`SCU_B_ALT] |=> card_clk == $past(alt_q)) else $error("alternate clock not routed");
  a_bit_len: assert property (@(posedge core_clk) disable iff (!nrst)
    st_q == SCU_TXB && ebnd && bitn_q != `SCU_LAST_BIT && etu_hi_q[`SCU_B_COMP] && bitn_q[0]
    |=> etu_cnt_q == $past(etu) - 11'h001) else $error("even bit not shortened");
endmodule

/* File: dv/scu_card_model.sv */
// Behavioural card on the open-drain I/O line: takes and sends character frames.
// Assumes a pull-up on the line and a bit length fixed in core_clk cycles.
`timescale 1ns/100ps
module scu_card_model #(
  parameter int BIT = 22
) (
  input wire logic core_clk, // System clock
  input wire logic io, // Resolved line level
  input wire logic conv_inverse, // Convention in use
  output logic pull_low, // Card pulls the line low
  output logic [7:0] got, // Last byte taken from the line
  output int got_n // Bytes taken so far
);
  logic sending = 1'b0;
  logic [9:0] fr;
  initial begin
    pull_low = 1'b0;
    got = 8'h00;
    got_n = 0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Line order: direct is LSB first at true level, inverse MSB first inverted
  function automatic logic [7:0] line_bits(input logic [7:0] b, input logic inv);
    for (int i = 0; i < 8; i++) line_bits[i] = inv ? ~b[7-i] : b[i];
  endfunction
  // Mid-bit sampling; own frames are skipped so a send is never echoed back
  always begin
    @(negedge io);
    if (!sending) begin
      repeat (BIT / 2) @(posedge core_clk);
      for (int i = 0; i < 10; i++) begin
        if (i > 0) repeat (BIT) @(posedge core_clk);
        fr[i] = io;
      end
      got = line_bits(fr[8:1], conv_inverse);
      got_n++;
    end
  end
  // Start, eight data bits, parity even on the line in direct convention, odd in inverse; two units kept free after
  task automatic send(input logic [7:0] b);
    logic [7:0] l;
    logic [9:0] s;
    l = line_bits(b, conv_inverse);
    s = {^l ^ conv_inverse, l, 1'b0};
    @(posedge core_clk);
    sending = 1'b1;
    for (int i = 0; i < 10; i++) begin
      pull_low <= ~s[i];
      repeat (BIT) @(posedge core_clk);
    end
    pull_low <= 1'b0;
    repeat (BIT * 2) @(posedge core_clk);
    sending = 1'b0;
  endtask
endmodule

/* File: dv/test_scu_regs.sv */
// Self-checking bench for the smart card UART register bank.
// Assumes the card model on the I/O line and a time unit of 11 ticks at prescale 1.
`timescale 1ns/100ps
module test_scu_regs;
  logic core_clk, nrst, sfr_wr, sfr_rd, conv_inverse, port_clk, io;
  logic card_io_out, card_io_oe, card_clk, irq, pull_low;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, got;
  logic [8:0] guard_time_value;
  logic [2:0] ev;
  int got_n, mismatches, comparisons;
  // Open-drain line with a pull-up
  assign io = ((card_io_oe && !card_io_out) || pull_low) ? 1'b0 : 1'b1;
  scu_regs dut (.core_clk(core_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .conv_inverse(conv_inverse),
    .guard_time_value(guard_time_value), .overcurrent_evt(ev[0]), .voltage_fault_evt(ev[1]),
    .wait_timeout_evt(ev[2]), .port_clk(port_clk), .card_io_in(io), .card_io_out(card_io_out),
    .card_io_oe(card_io_oe), .card_clk(card_clk), .irq(irq));
  scu_card_model #(.BIT(22)) card (.core_clk(core_clk), .io(io), .conv_inverse(conv_inverse),
    .pull_low(pull_low), .got(got), .got_n(got_n));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      mismatches++;
    end
  endtask
  // One-cycle strobes; read data is taken the edge after the read edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    @(posedge core_clk);
    #1 chk(what, exp, sfr_rdata);
  endtask
  // Enables sit in bank 1; leaves bank 0 selected with prescale code 0
  task automatic irq_en(input logic [7:0] d);
    wr(8'hab, 8'h01);
    wr(8'hae, d);
    wr(8'hab, 8'h00);
  endtask
  // Bounded wait for irq high, or for the card to count tgt bytes
  task automatic wait_done(input bit use_card, input int tgt);
    for (int i = 0; i < 2000; i++) begin
      @(posedge core_clk);
      if (use_card ? (got_n == tgt) : (irq === 1'b1)) return;
    end
    $display("MISMATCH wait expected done seen timeout");
    mismatches++;
    stop_test();
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk);
    ev <= 3'h1 << k;
    @(posedge core_clk);
    ev <= 3'h0;
  endtask
  // Rising edges of card_clk in 32 samples: exact for any phase
  task automatic count_rises(input logic [7:0] exp);
    logic p;
    logic [7:0] n;
    n = 8'h00;
    #1 p = card_clk;
    repeat (32) begin
      @(posedge core_clk);
      #1 if (card_clk && !p) n++;
      p = card_clk;
    end
    chk("card clock rises", exp, n);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    conv_inverse = 1'b0;
    guard_time_value = 9'h00c;
    ev = 3'h0;
    port_clk = 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(8'hab, 8'h08, "selection reset");
    rd(8'had, 8'h80, "status reset");
    wr(8'hab, 8'h09);
    rd(8'hae, 8'h00, "enable reset");
    rd(8'had, 8'h01, "unit high reset");
    rd(8'hac, 8'h74, "unit low reset");
    wr(8'hae, 8'hff);
    rd(8'hae, 8'hbf, "enable mask");
    wr(8'hab, 8'hff);
    rd(8'hab, 8'h5f, "selection mask");
    $display("Test registers done");
    // Each external event enabled alone, then masked with all others enabled
    for (int k = 0; k < 3; k++) begin
      irq_en(8'h20 >> k);
      pulse(k);
      wait_done(0, 0);
      rd(8'hae, 8'h20 >> k, "identification");
      repeat (3) @(posedge core_clk);
      chk("irq after clear", 8'h00, {7'h00, irq});
      irq_en(~(8'h20 >> k) & 8'hbf);
      pulse(k);
      repeat (3) @(posedge core_clk);
      chk("masked irq", 8'h00, {7'h00, irq});
      rd(8'hae, 8'h20 >> k, "masked identification");
    end
    $display("Test interrupts done");
    for (int k = 0; k < 4; k++) begin
      wr(8'hab, 8'h02 | 8'(k << 2));
      count_rises(8'h10 >> k);
    end
    wr(8'hab, 8'h08);
    port_clk <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("port clock", 8'h01, {7'h00, card_clk});
    $display("Test card clock done");
    // Time unit 11 ticks at prescale 1: 22 cycles a bit
    wr(8'hab, 8'h01);
    wr(8'hac, 8'h0b);
    wr(8'had, 8'h00);
    for (int c = 0; c < 2; c++) begin
      irq_en(8'h80);
      conv_inverse <= c[0];
      wr(8'haa, 8'h5c ^ 8'(c));
      wait_done(0, 0);
      rd(8'hae, 8'h80, "copy identification");
      rd(8'had, 8'h80, "empty after copy");
      irq_en(8'h04);
      wait_done(1, c + 1);
      chk("card byte", 8'h5c ^ 8'(c), got);
      wait_done(0, 0);
      rd(8'hae, 8'h04, "sent identification");
      irq_en(8'h02);
      repeat (44) @(posedge core_clk);
      card.send(8'ha3 ^ 8'(c));
      wait_done(0, 0);
      rd(8'had, 8'h82, "received flag");
      wr(8'hab, 8'h01);
      rd(8'haa, 8'ha3 ^ 8'(c), "receive buffer");
      wr(8'hab, 8'h00);
      rd(8'had, 8'h80, "flag after read");
      rd(8'hae, 8'h02, "received identification");
    end
    $display("Test card link done");
    // Guard enable loads 12 units; the written byte must wait them out
    wr(8'hab, 8'h40);
    wr(8'haa, 8'h3c);
    repeat (100) @(posedge core_clk);
    rd(8'had, 8'h00, "held by guard");
    chk("nothing sent in guard", 8'h02, 8'(got_n));
    wait_done(1, 3);
    chk("byte after guard", 8'h3c, got);
    $display("Test block guard done");
    stop_test();
  end
endmodule
